// *** usc_pkg.sv ***
// Purpose: Constants for the USB system configuration register block
// Assumes: APB slave, 32-bit data, one 16-bit register in the low half of word 0x00
// Notes: Unassigned bits read as zero
// Functional notes
// RULE1 - Bits 15-14 select the input clock: 00 is 12 MHz, 01 is 24 MHz, 10 is 48 MHz, 11 is reserved.
// RULE2 - Bit 13 enables the oscillation buffer when 1 and disables it when 0.
// RULE3 - Bit 11 runs the 48 MHz PLL, and both software and hardware may change it.
// RULE4 - Bit 10 gates the 48 MHz clock to the USB block, and both software and hardware may change it.
// RULE5 - Bit 7 at 0 fixes full speed (peripheral) or full/low speed (host); at 1 Hi-Speed is enabled and speed is detected.
// RULE6 - Bit 6 selects the peripheral role at 0 and the host role at 1.
// RULE7 - Bit 5 enables the D+ and D- pull-downs for the host role; software writes it 0 in the peripheral role.
// RULE8 - Bit 4 enables the D+ pull-up for the peripheral role; software writes it 0 in the host role.
// RULE9 - Bit 0 enables USB block operation at 1 and disables it at 0.
// RULE10 - Software always writes zero to unassigned bits 12, 9-8 and 3-1.
// RULE11 - Every defined field resets to zero, and hardware changes only the PLL and clock-gate bits.
package usc_pkg;
    localparam logic [7:0] USC_CFG_OFFSET = 8'h00;
    localparam logic [15:0] USC_CFG_RESET = 16'h0000;
    // Defined fields only, PLL bit included since software may write it
    localparam logic [15:0] USC_CFG_MASK = 16'hecf1;
    localparam int USC_XSEL_LSB = 14;
    localparam int USC_OSC_BUF_BIT = 13;
    localparam int USC_PLL_BIT = 11;
    localparam int USC_GATE_BIT = 10;
    localparam int USC_HS_BIT = 7;
    localparam int USC_ROLE_BIT = 6;
    localparam int USC_PD_BIT = 5;
    localparam int USC_PU_BIT = 4;
    localparam int USC_BLK_EN_BIT = 0;

    typedef enum logic [1:0] {
        USC_FREQ_12 = 2'b00,
        USC_FREQ_24 = 2'b01,
        USC_FREQ_48 = 2'b10,
        USC_FREQ_RSV = 2'b11
    } usc_freq_type;

    typedef enum logic [1:0] {
        USC_IDLE = 2'b00,
        USC_ACCESS = 2'b01
    } usc_state_type;
endpackage

// *** usc_hw_if.sv ***
`timescale 1ns/1ps
// Purpose: Hardware update path for the PLL and clock-gate bits
// Assumes: Single clock domain
// Notes: Set and clear requests are one-cycle pulses
interface usc_hw_if;
    logic pll_set;
    logic pll_clr;
    logic gate_set;
    logic gate_clr;
    modport core (input pll_set, input pll_clr, input gate_set, input gate_clr);
    modport ctl (output pll_set, output pll_clr, output gate_set, output gate_clr);
endinterface

// *** usc_hw_ctl.sv ***
`timescale 1ns/1ps
// Purpose: Hardware requests for the PLL and clock-gate bits
// Assumes: Pins synchronised here, three flip-flops each
// Notes: Rising edge of a request sets, falling edge clears
module usc_hw_ctl (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_pll_req,
    input wire logic i_gate_req,
    usc_hw_if.ctl hw
);
    logic [1:0] s1_ff;
    logic [1:0] s2_ff;
    logic [1:0] s3_ff;
    logic [1:0] nxt_s1;
    logic [1:0] nxt_s2;
    logic [1:0] nxt_s3;

    always_comb begin
        nxt_s1 = {i_gate_req, i_pll_req};
        nxt_s2 = s1_ff;
        nxt_s3 = s2_ff;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s1_ff <= 2'h0;
            s2_ff <= 2'h0;
            s3_ff <= 2'h0;
        end else begin
            s1_ff <= nxt_s1;
            s2_ff <= nxt_s2;
            s3_ff <= nxt_s3;
        end
    end

    // Edges only, so software writes stay in charge between requests
    assign hw.pll_set = s2_ff[0] & ~s3_ff[0]; // [RULE3]
    assign hw.pll_clr = ~s2_ff[0] & s3_ff[0]; // [RULE3]
    assign hw.gate_set = s2_ff[1] & ~s3_ff[1]; // [RULE4]
    assign hw.gate_clr = ~s2_ff[1] & s3_ff[1]; // [RULE4]
endmodule // usc_hw_ctl

// *** usc_sys_cfg.sv ***
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
// Purpose: System configuration register with APB access and decoded controls
// Assumes: 100 MHz clock, APB4 slave with pstrb, pready after one access cycle
// Notes: Hardware edge requests win over a software write in the same cycle
module usc_sys_cfg (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic i_pll_req,
    input wire logic i_gate_req,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [1:0] o_input_freq_select,
    output logic o_input_freq_reserved,
    output logic o_osc_buffer_enable,
    output logic o_pll_enable,
    output logic o_usb_block_clock_gate,
    output logic o_high_speed_enable,
    output logic o_role_select,
    output logic o_host_pulldown_enable,
    output logic o_device_pullup_enable,
    output logic o_usb_block_enable
);
    usc_hw_if hw ();

    usc_hw_ctl u_hw_ctl (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_pll_req(i_pll_req),
        .i_gate_req(i_gate_req),
        .hw(hw)
    );

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == usc_pkg::USC_CFG_OFFSET);
    endfunction

    usc_pkg::usc_state_type state_ff;
    usc_pkg::usc_state_type nxt_state;
    logic [15:0] cfg_ff;
    logic [15:0] nxt_cfg;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pready_ff;
    logic nxt_pready;
    logic pslverr_ff;
    logic nxt_pslverr;
    logic [10:0] out_ff;
    logic [10:0] nxt_out;
    logic [15:0] wr_val;
    logic do_wr;

    always_comb begin
        nxt_state = state_ff;
        nxt_pready = 1'b0;
        nxt_pslverr = 1'b0;
        nxt_prdata = prdata_ff;
        nxt_cfg = cfg_ff;
        do_wr = 1'b0;
        wr_val = cfg_ff;
        case (state_ff)
            usc_pkg::USC_IDLE: begin
                if (i_psel && !i_penable) begin
                    nxt_state = usc_pkg::USC_ACCESS;
                end
            end
            usc_pkg::USC_ACCESS: begin
                // One wait state keeps prdata registered
                nxt_pready = 1'b1;
                nxt_pslverr = !addr_hit(i_paddr);
                nxt_prdata = 32'h0;
                if (addr_hit(i_paddr) && !i_pwrite) begin
                    nxt_prdata = {16'h0, cfg_ff};
                end
                if (addr_hit(i_paddr) && i_pwrite) begin
                    do_wr = 1'b1;
                end
                nxt_state = usc_pkg::USC_IDLE;
            end
            default: begin
                nxt_state = usc_pkg::USC_IDLE;
            end
        endcase
        if (do_wr) begin
            // Unassigned bits dropped; software must write them zero anyway [RULE10]
            if (i_pstrb[0]) begin
                wr_val[7:0] = i_pwdata[7:0];
            end
            if (i_pstrb[1]) begin
                wr_val[15:8] = i_pwdata[15:8];
            end
            nxt_cfg = wr_val & usc_pkg::USC_CFG_MASK; // [RULE11]
        end
        // Hardware may only touch PLL and clock gate [RULE11]
        if (hw.pll_set) begin
            nxt_cfg[usc_pkg::USC_PLL_BIT] = 1'b1; // [RULE3]
        end else if (hw.pll_clr) begin
            nxt_cfg[usc_pkg::USC_PLL_BIT] = 1'b0; // [RULE3]
        end
        if (hw.gate_set) begin
            nxt_cfg[usc_pkg::USC_GATE_BIT] = 1'b1; // [RULE4]
        end else if (hw.gate_clr) begin
            nxt_cfg[usc_pkg::USC_GATE_BIT] = 1'b0; // [RULE4]
        end
    end

    always_comb begin
        nxt_out[1:0] = nxt_cfg[usc_pkg::USC_XSEL_LSB +: 2]; // [RULE1]
        nxt_out[2] = (nxt_cfg[usc_pkg::USC_XSEL_LSB +: 2] == usc_pkg::USC_FREQ_RSV); // [RULE1]
        nxt_out[3] = nxt_cfg[usc_pkg::USC_OSC_BUF_BIT]; // [RULE2]
        nxt_out[4] = nxt_cfg[usc_pkg::USC_PLL_BIT]; // [RULE3]
        // No clock to the block without the PLL running
        nxt_out[5] = nxt_cfg[usc_pkg::USC_GATE_BIT] & nxt_cfg[usc_pkg::USC_PLL_BIT]; // [RULE4]
        nxt_out[6] = nxt_cfg[usc_pkg::USC_HS_BIT]; // [RULE5]
        nxt_out[7] = nxt_cfg[usc_pkg::USC_ROLE_BIT]; // [RULE6]
        // Resistors follow the bits; role mismatch is software's to avoid
        nxt_out[8] = nxt_cfg[usc_pkg::USC_PD_BIT]; // [RULE7]
        nxt_out[9] = nxt_cfg[usc_pkg::USC_PU_BIT]; // [RULE8]
        nxt_out[10] = nxt_cfg[usc_pkg::USC_BLK_EN_BIT]; // [RULE9]
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_ff <= usc_pkg::USC_IDLE;
            cfg_ff <= usc_pkg::USC_CFG_RESET; // [RULE11]
            prdata_ff <= 32'h0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            out_ff <= 11'h0;
        end else begin
            state_ff <= nxt_state;
            cfg_ff <= nxt_cfg;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            out_ff <= nxt_out;
        end
    end

    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_input_freq_select = out_ff[1:0];
    assign o_input_freq_reserved = out_ff[2];
    assign o_osc_buffer_enable = out_ff[3];
    assign o_pll_enable = out_ff[4];
    assign o_usb_block_clock_gate = out_ff[5];
    assign o_high_speed_enable = out_ff[6];
    assign o_role_select = out_ff[7];
    assign o_host_pulldown_enable = out_ff[8];
    assign o_device_pullup_enable = out_ff[9];
    assign o_usb_block_enable = out_ff[10];
endmodule // usc_sys_cfg

// *** usc_sys_cfg_asserts.sv ***
// Purpose: Port checks of the configuration register
// Assumes: One clock, async active-high reset
// Notes: Sees top ports only
`timescale 1ns/1ps
module usc_sys_cfg_asserts (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic i_pll_req,
    input wire logic i_gate_req,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [1:0] o_input_freq_select,
    input wire logic o_input_freq_reserved,
    input wire logic o_osc_buffer_enable,
    input wire logic o_pll_enable,
    input wire logic o_usb_block_clock_gate,
    input wire logic o_high_speed_enable,
    input wire logic o_role_select,
    input wire logic o_host_pulldown_enable,
    input wire logic o_device_pullup_enable,
    input wire logic o_usb_block_enable
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wire wr_ok = o_pready && !o_pslverr && i_pwrite && i_pstrb[1:0] == 2'b11;
    property p_answer; i_psel && i_penable && !$past(i_penable) |=> o_pready; endproperty
    a_answer: assert property (p_answer) else $error("no ready after access");
    property p_pulse; o_pready |=> !o_pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_err; o_pready && i_paddr != 8'h00 |-> o_pslverr && (i_pwrite || o_prdata == 32'h0); endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_spare; o_pready && !i_pwrite |-> (o_prdata & 32'hffff130e) == 32'h0; endproperty
    a_spare: assert property (p_spare) else $error("unassigned bit reads one");
    property p_fields; wr_ok |=> {o_input_freq_select, o_osc_buffer_enable, o_high_speed_enable, o_role_select,
        o_host_pulldown_enable, o_device_pullup_enable, o_usb_block_enable}
        == $past({i_pwdata[15:13], i_pwdata[7:4], i_pwdata[0]}); endproperty
    a_fields: assert property (p_fields) else $error("field not taken");
    property p_gate; o_usb_block_clock_gate |-> o_pll_enable; endproperty
    a_gate: assert property (p_gate) else $error("gate without pll");
    property p_pin; $rose(i_pll_req) |-> ##[3:6] o_pll_enable; endproperty
    a_pin: assert property (p_pin) else $error("pll pin ignored");
    property p_pin_off; $fell(i_pll_req) |-> ##[3:6] !o_pll_enable; endproperty
    a_pin_off: assert property (p_pin_off) else $error("pll pin clear ignored");
    property p_gate_off; $fell(i_gate_req) |-> ##[3:6] !o_usb_block_clock_gate; endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate pin clear ignored");
    property p_rst; $fell(i_sys_rst) |-> !o_usb_block_enable && !o_pll_enable && o_input_freq_select == 2'b00; endproperty
    a_rst: assert property (p_rst) else $error("not cleared by reset");
endmodule // usc_sys_cfg_asserts
bind usc_sys_cfg usc_sys_cfg_asserts u_chk (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb),
    .i_pll_req(i_pll_req),
    .i_gate_req(i_gate_req),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_input_freq_select(o_input_freq_select),
    .o_input_freq_reserved(o_input_freq_reserved),
    .o_osc_buffer_enable(o_osc_buffer_enable),
    .o_pll_enable(o_pll_enable),
    .o_usb_block_clock_gate(o_usb_block_clock_gate),
    .o_high_speed_enable(o_high_speed_enable),
    .o_role_select(o_role_select),
    .o_host_pulldown_enable(o_host_pulldown_enable),
    .o_device_pullup_enable(o_device_pullup_enable),
    .o_usb_block_enable(o_usb_block_enable)
);

// *** usc_pin_model.sv ***
// Purpose: Hardware side driving the pll and gate request pins
// Assumes: Bench asks for pin levels
// Notes: Lag sets prompt or slow response
`timescale 1ns/1ps
module usc_pin_model (
    input wire logic i_clk,
    input wire logic [1:0] i_want,
    input wire logic [3:0] i_lag,
    output logic [1:0] o_req
);
    logic [3:0] cnt_ff = 4'h0;
    initial o_req = 2'b00;
    // Level follows after the lag
    always @(posedge i_clk) begin
        if (i_want == o_req) cnt_ff <= 4'h0;
        else if (cnt_ff >= i_lag) o_req <= i_want;
        else cnt_ff <= cnt_ff + 4'h1;
    end
endmodule // usc_pin_model

// *** usc_system_config_register_bench.sv ***
// Purpose: Self-checking bench of the configuration register
// Assumes: APB master, xorshift stimulus
// Notes: Model tracks register in mdl
`timescale 1ns/1ps
module usc_system_config_register_bench;
    logic i_clk = 0, i_sys_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, err;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0, rd, seed = 32'd47;
    logic [3:0] i_pstrb = 4'h0, lag = 4'h0, s;
    logic [1:0] want = 2'b00, req, o_input_freq_select;
    logic [15:0] mdl = 16'h0, d;
    wire i_pll_req = req[1];
    wire i_gate_req = req[0];
    logic [31:0] o_prdata;
    logic o_pready, o_pslverr, o_input_freq_reserved, o_osc_buffer_enable, o_pll_enable, o_usb_block_clock_gate;
    logic o_high_speed_enable, o_role_select, o_host_pulldown_enable, o_device_pullup_enable, o_usb_block_enable;
    int miscompares = 0, tests_run = 0, cycles = 0;
    usc_sys_cfg DUT (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_psel(i_psel),
        .i_penable(i_penable),
        .i_pwrite(i_pwrite),
        .i_paddr(i_paddr),
        .i_pwdata(i_pwdata),
        .i_pstrb(i_pstrb),
        .i_pll_req(i_pll_req),
        .i_gate_req(i_gate_req),
        .o_prdata(o_prdata),
        .o_pready(o_pready),
        .o_pslverr(o_pslverr),
        .o_input_freq_select(o_input_freq_select),
        .o_input_freq_reserved(o_input_freq_reserved),
        .o_osc_buffer_enable(o_osc_buffer_enable),
        .o_pll_enable(o_pll_enable),
        .o_usb_block_clock_gate(o_usb_block_clock_gate),
        .o_high_speed_enable(o_high_speed_enable),
        .o_role_select(o_role_select),
        .o_host_pulldown_enable(o_host_pulldown_enable),
        .o_device_pullup_enable(o_device_pullup_enable),
        .o_usb_block_enable(o_usb_block_enable)
    );
    usc_pin_model PIN (.i_clk(i_clk), .i_want(want), .i_lag(lag), .o_req(req));
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) if (++cycles == 20000) begin miscompares++; end_sim(); end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task end_sim();
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] v, input logic [31:0] e);
        tests_run++;
        if (v !== e) begin miscompares++; $display("BAD %s exp %h seen %h", n, e, v); end
    endtask
    // Request held until ready is high at a rising edge; answer taken at that edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] st);
        @(posedge i_clk);
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_pstrb} <= {2'b10, w, a, wd, st};
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        {i_psel, i_penable} <= 2'b00;
    endtask
    task cmp_all();
        apb(0, 8'h00, 32'h0, 4'h0);
        chk("cfg", rd, {16'h0, mdl});
        chk("outs", 32'({o_input_freq_select, o_input_freq_reserved, o_osc_buffer_enable, o_pll_enable,
            o_usb_block_clock_gate, o_high_speed_enable, o_role_select, o_host_pulldown_enable,
            o_device_pullup_enable, o_usb_block_enable}), 32'({mdl[15:14], &mdl[15:14], mdl[13], mdl[11],
            mdl[10] & mdl[11], mdl[7:4], mdl[0]}));
    endtask
    initial begin
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 0;
        cmp_all();
        for (int k = 0; k < 40; k++) begin
            d = 16'(xs()) & usc_pkg::USC_CFG_MASK;
            if (d[6]) d[4] = 0; else d[5] = 0;
            s = (k < 30) ? 4'hf : 4'(xs());
            apb(1, 8'h00, {16'h0, d}, s);
            if (s[0]) mdl[7:0] = d[7:0];
            if (s[1]) mdl[15:8] = d[15:8];
            cmp_all();
        end
        apb(1, 8'h04, 32'hffff, 4'hf);
        chk("werr", 32'(err), 32'h1);
        apb(0, 8'hfc, 32'h0, 4'h0);
        chk("rerr", 32'(err), 32'h1);
        chk("rdat", rd, 32'h0);
        cmp_all();
        for (int k = 0; k < 2; k++) begin
            lag <= k ? 4'h7 : 4'h0;
            want <= 2'b11;
            repeat (25) @(posedge i_clk);
            mdl[11:10] = 2'b11;
            cmp_all();
            want <= 2'b00;
            repeat (25) @(posedge i_clk);
            mdl[11:10] = 2'b00;
            cmp_all();
        end
        i_sys_rst <= 1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 0;
        mdl = 16'h0;
        cmp_all();
        end_sim();
    end
endmodule // usc_system_config_register_bench
